/* File: src/scu_system_control_unit.sv */
// system control unit: interrupt masking, level scheme, bus timer, speed control
// Behaviour
// - two masks gate requests to processor
// - reset clears both masks
// - status shows all seven request levels
// - status shows raw lines before masking
// - register write raises level one request
// - acknowledge outputs only on levels five, six
// - own levels one, three always autovectored
// - power fail gives level seven request
// - bus error after sixteen microseconds
// - control bit zero enables cache
// - control bit one selects fast clock
//
// Register access over AXI4-Lite and the register addresses were decided locally.
module scu_system_control_unit #(
    parameter int timeout_cycles = scu_pkg::bus_timeout_cycles
) (
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  reset_n,
    // axi4-lite write address and data
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [7:0]            s_axi_awaddr,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    // axi4-lite write response
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    output logic [1:0]                 s_axi_bresp,
    // axi4-lite read
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    input  wire logic [7:0]            s_axi_araddr,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    // request pins and processor cycle pins
    input  wire scu_pkg::scu_pins_type pins,
    // processor side
    output logic [2:0]                 request_level,
    output logic                       interrupt_acknowledge_five,
    output logic                       interrupt_acknowledge_six,
    output logic                       autovector,
    output logic                       bus_error,
    // board control
    output logic                       cache_enable,
    output logic                       fast_clock,
    output logic                       irq
);
    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (timeout_cycles < 2 || timeout_cycles > 65535) begin : g_bad_timeout
        $error("timeout_cycles out of range");
    end

    localparam int pin_width = $bits(scu_pkg::scu_pins_type);

    // returns the highest set level of a request vector, zero when none
    function automatic logic [2:0] highest_level(input logic [7:1] lines);
        logic [2:0] level;
        level = 3'h0;
        for (int i = 1; i <= 7; i++) begin
            if (lines[i]) begin
                level = 3'(i);
            end
        end
        return level;
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers: three stages, change taken when 2 and 3 agree
    // ------------------------------------------------------------
    logic [pin_width-1:0] sync_one;   // metastable stage, read only by sync_two
    logic [pin_width-1:0] sync_two;   // second stage
    logic [pin_width-1:0] sync_three; // third stage
    logic [pin_width-1:0] stable;     // filtered pin value
    scu_pkg::scu_pins_type pin;       // filtered pins as a struct

    for (genvar b = 0; b < pin_width; b++) begin : g_sync
        // idle value is one for the active-low lines, zero elsewhere
        localparam logic idle_value = (b >= 4 && b <= 6) ? 1'b1 : 1'b0;
        always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
                sync_one[b]   <= idle_value;
                sync_two[b]   <= idle_value;
                sync_three[b] <= idle_value;
                stable[b]     <= idle_value;
            end else begin
                sync_one[b]   <= pins[b];
                sync_two[b]   <= sync_one[b];
                sync_three[b] <= sync_two[b];
                // a single-stage glitch never reaches the logic
                if (sync_two[b] == sync_three[b]) begin
                    stable[b] <= sync_three[b];
                end
            end
        end
    end
    assign pin = scu_pkg::scu_pins_type'(stable);

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [7:1]                system_mask;    // main-system enables
    logic [7:1]                expansion_mask; // expansion-bus enables
    logic                      soft_request;   // software level one request
    scu_pkg::scu_control_type  control;        // speed and cache
    logic [1:0]                event_status;   // sticky events
    logic [1:0]                event_enable;   // event enables
    logic                      power_fail_seen; // previous power fail level

    // ------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------
    logic       aw_held;     // address taken, waiting for data
    logic       w_held;      // data taken, waiting for address
    logic [7:0] write_addr;  // captured address
    logic [7:0] write_data;  // captured low byte
    logic       write_lane;  // low byte strobe
    logic       write_now;   // both halves present this cycle

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign write_now     = aw_held && w_held;

    // capture address and data independently, in either order
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            aw_held    <= 1'b0;
            w_held     <= 1'b0;
            write_addr <= 8'h00;
            write_data <= 8'h00;
            write_lane <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held    <= 1'b1;
                write_addr <= s_axi_awaddr;
            end else if (write_now) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held     <= 1'b1;
                write_data <= s_axi_wdata[7:0];
                write_lane <= s_axi_wstrb[0];
            end else if (write_now) begin
                w_held <= 1'b0;
            end
        end
    end

    // decodes whether an offset names a register
    function automatic logic mapped(input logic [7:0] addr);
        return addr <= scu_pkg::event_enable_offset && addr[1:0] == 2'h0;
    endfunction

    // write response one cycle after both halves meet
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= scu_pkg::resp_okay;
        end else if (write_now) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(write_addr) ? scu_pkg::resp_okay : scu_pkg::resp_slverr;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    logic do_write; // write of the low byte lane
    assign do_write = write_now && write_lane;

    // ------------------------------------------------------------
    // masks and control: cleared by reset, read-write
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            system_mask    <= scu_pkg::mask_reset[7:1];
            expansion_mask <= scu_pkg::mask_reset[7:1];
            control        <= scu_pkg::control_reset;
            event_enable   <= scu_pkg::event_reset;
        end else if (do_write) begin
            unique case (write_addr)
                scu_pkg::system_mask_offset:    system_mask    <= write_data[7:1];
                scu_pkg::expansion_mask_offset: expansion_mask <= write_data[7:1];
                scu_pkg::control_offset:        control        <= write_data[1:0];
                scu_pkg::event_enable_offset:   event_enable   <= write_data[1:0];
                default: ;
            endcase
        end
    end

    // software request: writing one raises level one, writing zero withdraws it
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            soft_request <= 1'b0;
        end else if (do_write && write_addr == scu_pkg::soft_request_offset) begin
            soft_request <= write_data[0];
        end
    end

    // board controls come straight from flops; routing is the board's job
    assign cache_enable = control.cache_enable;
    assign fast_clock   = control.fast_clock;

    // ------------------------------------------------------------
    // bus timer
    // ------------------------------------------------------------
    scu_pkg::scu_timer_type timer_state;      // timer phase
    scu_pkg::scu_timer_type next_timer_state; // next phase
    logic [15:0]            timer_count_value; // cycles in the current bus cycle
    logic                   timeout_hit;       // limit reached this cycle

    assign timeout_hit = timer_count_value == 16'(timeout_cycles - 1);

    // one fault per stalled cycle; release of the strobe rearms the timer
    always_comb begin
        next_timer_state = timer_state;
        unique case (timer_state)
            scu_pkg::timer_idle:
                if (!pin.cycle_strobe_n) next_timer_state = scu_pkg::timer_count;
            scu_pkg::timer_count:
                if (pin.cycle_strobe_n) next_timer_state = scu_pkg::timer_idle;
                else if (!pin.cycle_end_n) next_timer_state = scu_pkg::timer_ended;
                else if (timeout_hit) next_timer_state = scu_pkg::timer_fault;
            scu_pkg::timer_fault, scu_pkg::timer_ended:
                if (pin.cycle_strobe_n) next_timer_state = scu_pkg::timer_idle;
        endcase
    end

    // state and counter; counter is zero outside a timed cycle
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            timer_state       <= scu_pkg::timer_idle;
            timer_count_value <= 16'h0000;
        end else begin
            timer_state <= next_timer_state;
            if (next_timer_state == scu_pkg::timer_count && timer_state == scu_pkg::timer_count) begin
                timer_count_value <= timer_count_value + 16'h0001;
            end else begin
                timer_count_value <= 16'h0000;
            end
        end
    end

    assign bus_error = timer_state == scu_pkg::timer_fault;

    // ------------------------------------------------------------
    // sticky events: set wins over a clear in the same cycle
    // ------------------------------------------------------------
    logic [1:0] event_set;   // events this cycle
    logic [1:0] event_wipe;  // software clear this cycle

    assign event_set[scu_pkg::timeout_event_bit] = timer_state == scu_pkg::timer_count
                                                   && next_timer_state == scu_pkg::timer_fault;
    assign event_set[scu_pkg::power_fail_event_bit] = !pin.power_fail_n && power_fail_seen;
    assign event_wipe = (do_write && write_addr == scu_pkg::event_clear_offset)
                        ? write_data[1:0] : 2'h0;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            event_status    <= scu_pkg::event_reset;
            power_fail_seen <= 1'b1;
        end else begin
            event_status    <= (event_status & ~event_wipe) | event_set;
            power_fail_seen <= pin.power_fail_n;
        end
    end

    assign irq = |(event_status & event_enable);

    // ------------------------------------------------------------
    // request gating and level scheme
    // ------------------------------------------------------------
    logic [7:1] gated; // enabled requests per level

    always_comb begin
        gated = (pin.system_lines & system_mask) | (pin.expansion_lines & expansion_mask);
        gated[7] = (pin.expansion_lines[7] & expansion_mask[7])
                   | !pin.power_fail_n;
        gated[1] = gated[1] | (soft_request & system_mask[1]);
        gated[3] = gated[3] | (irq & system_mask[3]);
    end

    // registered level code to the processor
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            request_level <= 3'h0;
        end else begin
            request_level <= highest_level(gated);
        end
    end

    // acknowledge steering: vector supplier only on five and six
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            interrupt_acknowledge_five <= 1'b0;
            interrupt_acknowledge_six  <= 1'b0;
            autovector                 <= 1'b0;
        end else begin
            interrupt_acknowledge_five <= pin.ack_cycle && pin.ack_level == 3'h5;
            interrupt_acknowledge_six  <= pin.ack_cycle && pin.ack_level == 3'h6;
            autovector <= pin.ack_cycle && pin.ack_level != 3'h5
                          && pin.ack_level != 3'h6;
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;

    // status registers carry the synchronised raw lines
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= scu_pkg::resp_okay;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= mapped(s_axi_araddr) ? scu_pkg::resp_okay : scu_pkg::resp_slverr;
            unique case (s_axi_araddr)
                scu_pkg::system_mask_offset:      s_axi_rdata <= {24'h0, system_mask, 1'b0};
                scu_pkg::expansion_mask_offset:   s_axi_rdata <= {24'h0, expansion_mask, 1'b0};
                scu_pkg::system_status_offset:    s_axi_rdata <= {24'h0, pin.system_lines, 1'b0};
                scu_pkg::expansion_status_offset: s_axi_rdata <= {24'h0, pin.expansion_lines,
                                                                  !pin.power_fail_n};
                scu_pkg::soft_request_offset:     s_axi_rdata <= {31'h0, soft_request};
                scu_pkg::control_offset:          s_axi_rdata <= {30'h0, control};
                scu_pkg::event_status_offset:     s_axi_rdata <= {30'h0, event_status};
                scu_pkg::event_enable_offset:     s_axi_rdata <= {30'h0, event_enable};
                default:                          s_axi_rdata <= 32'h0000_0000;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence stalled_cycle;
        timer_state == scu_pkg::timer_count && timeout_hit && pin.cycle_end_n
        && !pin.cycle_strobe_n;
    endsequence
    a_mask_blocks_level: assert property (@(posedge clock) disable iff (!reset_n)
        (system_mask == 7'h0 && expansion_mask == 7'h0 && pin.power_fail_n && !irq
         && !soft_request) [*2] |-> request_level == 3'h0)
        else $error("masked request reached processor");
    a_reset_clears_masks: assert property (@(posedge clock)
        $rose(reset_n) |-> system_mask == 7'h0 && expansion_mask == 7'h0)
        else $error("mask not clear after reset");
    a_status_raw_lines: assert property (@(posedge clock) disable iff (!reset_n)
        s_axi_arvalid && s_axi_arready && s_axi_araddr == scu_pkg::system_status_offset
        |=> s_axi_rdata[7:1] == $past(pin.system_lines))
        else $error("status does not show raw lines");
    a_soft_level_one: assert property (@(posedge clock) disable iff (!reset_n)
        soft_request && system_mask[1] |=> request_level >= 3'h1)
        else $error("software request missing");
    a_ack_only_five_six: assert property (@(posedge clock) disable iff (!reset_n)
        interrupt_acknowledge_five |-> !interrupt_acknowledge_six && !autovector)
        else $error("acknowledge overlap");
    a_own_autovector: assert property (@(posedge clock) disable iff (!reset_n)
        pin.ack_cycle && (pin.ack_level == 3'h1 || pin.ack_level == 3'h3) |=> autovector)
        else $error("own level not autovectored");
    a_power_fail_seven: assert property (@(posedge clock) disable iff (!reset_n)
        !pin.power_fail_n |=> request_level == 3'h7)
        else $error("power fail not at level seven");
    a_timeout_error: assert property (@(posedge clock) disable iff (!reset_n)
        stalled_cycle |=> bus_error ##1 (bus_error || pin.cycle_strobe_n))
        else $error("bus error not raised on timeout");
    a_cache_follows_bit: assert property (@(posedge clock) disable iff (!reset_n)
        do_write && write_addr == scu_pkg::control_offset
        |=> cache_enable == $past(write_data[0]) && fast_clock == $past(write_data[1]))
        else $error("control bits not applied");
    a_error_once: assert property (@(posedge clock) disable iff (!reset_n)
        $fell(bus_error) |-> timer_state == scu_pkg::timer_idle)
        else $error("bus error ended without cycle release");
endmodule // scu_system_control_unit

/* File: src/scu_pkg.sv */
// package of constants and types for the system control unit
package scu_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] system_mask_offset    = 8'h00; // main-system mask
    localparam logic [7:0] expansion_mask_offset = 8'h04; // expansion-bus mask
    localparam logic [7:0] system_status_offset  = 8'h08; // raw main-system lines
    localparam logic [7:0] expansion_status_offset = 8'h0c; // raw expansion lines
    localparam logic [7:0] soft_request_offset   = 8'h10; // level one request
    localparam logic [7:0] control_offset        = 8'h14; // speed and cache
    localparam logic [7:0] event_status_offset   = 8'h18; // sticky events
    localparam logic [7:0] event_clear_offset    = 8'h1c; // write one to clear
    localparam logic [7:0] event_enable_offset   = 8'h20; // event enables
    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int         cache_enable_bit      = 0;
    localparam int         fast_clock_bit        = 1;
    localparam int         timeout_event_bit     = 0;
    localparam int         power_fail_event_bit  = 1;
    localparam logic [7:0] mask_reset            = 8'h00;
    localparam logic [1:0] control_reset         = 2'h0;
    localparam logic [1:0] event_reset           = 2'h0;
    localparam logic [1:0] resp_okay             = 2'h0;
    localparam logic [1:0] resp_slverr           = 2'h2;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int clock_mhz        = 125;
    localparam int bus_timeout_us   = 16;
    localparam int bus_timeout_cycles = bus_timeout_us * clock_mhz;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic fast_clock;   // bit 1
        logic cache_enable; // bit 0
    } scu_control_type;
    typedef struct packed {
        logic [7:1] system_lines;    // main-system requests
        logic [7:1] expansion_lines; // expansion-bus requests
        logic       power_fail_n;    // expansion power fail
        logic       cycle_strobe_n;  // processor cycle in progress
        logic       cycle_end_n;     // cycle terminated
        logic       ack_cycle;       // acknowledge cycle
        logic [2:0] ack_level;       // level being acknowledged
    } scu_pins_type;
    typedef enum logic [1:0] {
        timer_idle  = 2'h0,
        timer_count = 2'h1,
        timer_fault = 2'h3,
        timer_ended = 2'h2
    } scu_timer_type;
endpackage

/* File: tb/scu_far_side.sv */
// far-side model: request sources and processor bus cycles
module scu_far_side (
    // clock
    input  wire logic             clock,
    // stimulus from the bench
    input  wire logic [13:0]      lines,
    input  wire logic             fail_n,
    input  wire logic [3:0]       ack,
    input  wire logic             start,
    input  wire logic             stall,
    // block side
    input  wire logic             bus_error,
    output scu_pkg::scu_pins_type pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       busy = 1'b0; // strobe held low
    logic [3:0] age  = 4'h0; // cycles into the bus cycle
    // a stalled cycle ends only when the bus error arrives
    always @(posedge clock) begin
        age <= busy ? age + 4'h1 : 4'h0;
        if (start) begin
            busy <= 1'b1;
        end else if (bus_error || (!stall && age == 4'hc)) begin
            busy <= 1'b0;
        end
    end
    // terminate stays low until strobe is released, pulled high otherwise
    assign pins = '{lines[13:7], lines[6:0], fail_n, !busy,
                    !(busy && !stall && age > 4'h9), ack[3], ack[2:0]};
endmodule // scu_far_side

/* File: tb/system_control_unit_bench.sv */
// self-checking bench for the system control unit
module system_control_unit_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 1'b0, reset_n = 1'b0, fail_n = 1'b1, start = 1'b0, stall = 1'b0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, m1, m2;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [2:0]  request_level;
    logic        ack_five, ack_six, autovector, bus_error, cache_enable, fast_clock, irq;
    logic [13:0] lines = 14'h0;
    logic [3:0]  ack = 4'h0;
    logic [33:0] wq[$], rq[$]; // expected answers, oldest first
    scu_pkg::scu_pins_type pins;
    int          failures = 0, samples_checked = 0, cycles = 0, n;
    scu_far_side far (.clock, .lines, .fail_n, .ack, .start, .stall, .bus_error, .pins);
    scu_system_control_unit #(.timeout_cycles(20)) DUT (
        .clock, .reset_n, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
        .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_bvalid, .s_axi_bready(1'b1),
        .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
        .s_axi_rready(1'b1), .s_axi_rdata, .s_axi_rresp, .pins, .request_level,
        .interrupt_acknowledge_five(ack_five), .interrupt_acknowledge_six(ack_six),
        .autovector, .bus_error, .cache_enable, .fast_clock, .irq);
    initial forever #4 clock = ~clock;
    task automatic complete_run;
        if (failures == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic cmp(input string name, input logic [33:0] exp, input logic [33:0] got);
        samples_checked++;
        if (exp !== got) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clock);
    endtask
    // master write: both halves offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        logic ra, rw; // ready seen with valid before the coming edge
        wq.push_back(34'(r));
        s_axi_awaddr <= a;
        s_axi_wdata <= 32'(d);
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(negedge clock);
            ra = s_axi_awvalid && s_axi_awready;
            rw = s_axi_wvalid && s_axi_wready;
            @(posedge clock);
            if (ra) s_axi_awvalid <= 1'b0;
            if (rw) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        logic ra; // ready seen with valid before the coming edge
        rq.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(negedge clock);
            ra = s_axi_arvalid && s_axi_arready;
            @(posedge clock);
            if (ra) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
    endtask
    function automatic int top(input logic [7:0] v);
        top = 0;
        for (int i = 1; i < 8; i++) if (v[i]) top = i;
    endfunction
    // watcher: each answer against the oldest note; also the hang limit
    always @(posedge clock) begin
        if (s_axi_bvalid) cmp("bresp", wq.pop_front(), 34'(s_axi_bresp));
        if (s_axi_rvalid) cmp("rdata", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            complete_run();
        end
    end
    initial begin
        void'($urandom(396));
        tick(4);
        reset_n <= 1'b1;
        tick(1);
        rd(8'h00, 34'h0);
        rd(8'h04, 34'h0);
        rd(8'h24, {2'h2, 32'h0});
        wr(8'h24, 8'h55, 2'h2);
        repeat (3) begin
            lines <= 14'($urandom);
            m1 = 8'($urandom) & 8'h7e; // main-system line seven never reaches level seven
            m2 = 8'($urandom) & 8'hfe;
            wr(8'h00, m1, 2'h0);
            wr(8'h04, m2, 2'h0);
            tick(8);
            rd(8'h08, 34'({lines[13:7], 1'b0}));
            rd(8'h0c, 34'({lines[6:0], 1'b0}));
            rd(8'h04, 34'(m2));
            n = top(({lines[13:7], 1'b0} & m1) | ({lines[6:0], 1'b0} & m2));
            cmp("request_level", 34'(n), 34'(request_level));
        end
        lines <= 14'h0;
        wr(8'h00, 8'h02, 2'h0);
        wr(8'h10, 8'h01, 2'h0);
        tick(8);
        cmp("request_level", 34'h1, 34'(request_level));
        for (int l = 1; l < 8; l++) begin
            ack <= {1'b1, 3'(l)};
            tick(8);
            cmp("ack_five", 34'(l == 5), 34'(ack_five));
            cmp("ack_six", 34'(l == 6), 34'(ack_six));
            cmp("autovector", 34'(l != 5 && l != 6), 34'(autovector));
        end
        ack <= 4'h0;
        wr(8'h20, 8'h03, 2'h0);
        fail_n <= 1'b0;
        tick(8);
        cmp("request_level", 34'h7, 34'(request_level));
        rd(8'h18, 34'h2);
        fail_n <= 1'b1;
        cmp("irq", 34'h1, 34'(irq));
        wr(8'h00, 8'h08, 2'h0);
        tick(8);
        cmp("request_level", 34'h3, 34'(request_level));
        wr(8'h1c, 8'h02, 2'h0);
        tick(1);
        cmp("irq", 34'h0, 34'(irq));
        wr(8'h14, 8'h03, 2'h0);
        tick(1);
        cmp("cache", 34'h1, 34'(cache_enable));
        cmp("fast", 34'h1, 34'(fast_clock));
        wr(8'h14, 8'h02, 2'h0);
        rd(8'h14, 34'h2);
        cmp("cache", 34'h0, 34'(cache_enable));
        stall <= 1'b1;
        start <= 1'b1;
        tick(1);
        start <= 1'b0;
        tick(20);
        cmp("bus_error", 34'h0, 34'(bus_error));
        for (n = 0; n < 15 && bus_error !== 1'b1; n++) tick(1);
        cmp("bus_error", 34'h1, 34'(bus_error));
        cmp("irq", 34'h1, 34'(irq));
        tick(12);
        cmp("bus_error", 34'h0, 34'(bus_error));
        stall <= 1'b0;
        start <= 1'b1;
        tick(1);
        start <= 1'b0;
        tick(40);
        cmp("bus_error", 34'h0, 34'(bus_error));
        complete_run();
    end
endmodule // system_control_unit_bench
